// ===== verilog/tta_map.vh
// constants for the two-thread pipeline arbiter
`ifndef TTA_MAP_VH
`define TTA_MAP_VH
`define TTA_THREADS      2
`define TTA_DISPATCH_MAX 6
`define TTA_ROB_DEPTH    32
`define TTA_ROB_HALF     16
`define TTA_UQ_DEPTH     16
`define TTA_UQ_HALF      8
`define TTA_PTR_RESET    1'b1
`endif

// ===== verilog/tta_fifo.v
// parameterised valid/ready fifo
`timescale 1ns/1ps
module tta_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
    if (!rstn)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // tta_fifo

// ===== verilog/tta_arbiter.v
// two-thread pipeline arbiter: fetch, uop queue, dispatch, reorder, retire, commit
`timescale 1ns/1ps
`include "tta_map.vh"
module tta_arbiter #(
  parameter UW = 16
) (
  input  wire          CLK,
  input  wire          RSTN,
  input  wire [1:0]    FETCH_REQ,
  input  wire [1:0]    FETCH_MISS,
  input  wire [1:0]    FILL_RETURN,
  output reg  [1:0]    FETCH_GNT,
  input  wire [1:0]    UOP_VALID,
  input  wire [UW-1:0] UOP_DATA,
  output reg  [1:0]    UOP_READY,
  input  wire [1:0]    RENAME_READY,
  output reg  [1:0]    RENAME_VALID,
  output reg  [UW-1:0] RENAME_DATA,
  input  wire [5:0]    SCHED_READY,
  output reg  [5:0]    DISPATCH,
  output reg  [2:0]    DISPATCH_CNT,
  input  wire [1:0]    ROB_ALLOC,
  input  wire [1:0]    ROB_DONE,
  output reg  [1:0]    ROB_FULL,
  output reg  [1:0]    RETIRE,
  input  wire [1:0]    STORE_PEND,
  output reg  [1:0]    COMMIT
);
  localparam HW = 5;
  // uop queue: one fifo per thread keeps each thread's progress independent
  wire [1:0]    uq_in_ready;
  wire [1:0]    uq_out_valid;
  wire [UW-1:0] uq_out_data [0:1];
  wire [1:0]    uq_pop;
  reg  [1:0]    fetch_stall_q;
  reg           fetch_last_q;
  reg           ren_last_q;
  reg           ret_last_q;
  reg           com_last_q;
  reg  [HW-1:0] rob_cnt_q [0:1];
  wire [1:0]    fetch_can;
  wire [1:0]    fetch_g;
  wire [1:0]    ren_can;
  wire [1:0]    ren_g;
  wire [1:0]    ret_can;
  wire [1:0]    ret_g;
  wire [1:0]    com_g;
  wire [1:0]    rob_take;
  wire [5:0]    disp_d;
  wire [2:0]    disp_cnt_d;

  // two-way round robin; last=1 means thread 1 was granted last
  function [1:0] pick;
    input [1:0] can;
    input       last;
    begin
      if (can == 2'b11)
        pick = last ? 2'b01 : 2'b10;
      else
        pick = can;
    end
  endfunction

  function [2:0] popcnt6;
    input [5:0] v;
    integer k;
    begin
      popcnt6 = 3'h0;
      for (k = 0; k < 6; k = k + 1)
        popcnt6 = popcnt6 + {2'b00, v[k]};
    end
  endfunction

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1)
    begin : g_thr
      tta_fifo #(
        .WIDTH (UW),
        .DEPTH (`TTA_UQ_HALF),
        .AW    (3)
      ) u_uq (
        .clk       (CLK),
        .rstn      (RSTN),
        .in_valid  (UOP_VALID[t]),
        .in_ready  (uq_in_ready[t]),
        .in_data   (UOP_DATA),
        .out_valid (uq_out_valid[t]),
        .out_ready (uq_pop[t]),
        .out_data  (uq_out_data[t]),
        .level     ()
      );
      // a miss takes the thread out of contention in its own cycle, not one later
      assign fetch_can[t] = FETCH_REQ[t] & ~fetch_stall_q[t] & ~FETCH_MISS[t];
      assign ren_can[t]   = uq_out_valid[t] & RENAME_READY[t];
      assign uq_pop[t]    = ren_g[t];
      assign rob_take[t]  = ROB_ALLOC[t] & (rob_cnt_q[t] < `TTA_ROB_HALF);
      assign ret_can[t]   = ROB_DONE[t] & (rob_cnt_q[t] != {HW{1'b0}});
      always @(posedge CLK)
      begin
        if (!RSTN)
        begin
          fetch_stall_q[t] <= 1'b0;
          rob_cnt_q[t]     <= {HW{1'b0}};
        end
        else
        begin
          // a miss sets the stall; the fill return clears it, miss wins on a tie
          if (FETCH_MISS[t])
            fetch_stall_q[t] <= 1'b1;
          else if (FILL_RETURN[t])
            fetch_stall_q[t] <= 1'b0;
          rob_cnt_q[t] <= rob_cnt_q[t] + {{(HW-1){1'b0}}, rob_take[t]}
                          - {{(HW-1){1'b0}}, ret_g[t]};
        end
      end
    end
  endgenerate

  assign fetch_g = pick(fetch_can, fetch_last_q);
  assign ren_g   = pick(ren_can, ren_last_q);
  assign ret_g   = pick(ret_can, ret_last_q);
  assign com_g   = pick(STORE_PEND, com_last_q);
  // thread-blind: only operand readiness matters, capped at six lanes
  assign disp_d     = SCHED_READY;
  assign disp_cnt_d = popcnt6(SCHED_READY);

  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      fetch_last_q <= `TTA_PTR_RESET;
      ren_last_q   <= `TTA_PTR_RESET;
      ret_last_q   <= `TTA_PTR_RESET;
      com_last_q   <= `TTA_PTR_RESET;
      FETCH_GNT    <= 2'h0;
      UOP_READY    <= 2'h0;
      RENAME_VALID <= 2'h0;
      RENAME_DATA  <= {UW{1'b0}};
      DISPATCH     <= 6'h00;
      DISPATCH_CNT <= 3'h0;
      ROB_FULL     <= 2'h0;
      RETIRE       <= 2'h0;
      COMMIT       <= 2'h0;
    end
    else
    begin
      if (fetch_can == 2'b11)
        fetch_last_q <= fetch_g[1];
      if (ren_can == 2'b11)
        ren_last_q <= ren_g[1];
      if (ret_can == 2'b11)
        ret_last_q <= ret_g[1];
      if (STORE_PEND == 2'b11)
        com_last_q <= com_g[1];
      FETCH_GNT    <= fetch_g;
      UOP_READY    <= uq_in_ready;
      RENAME_VALID <= ren_g;
      RENAME_DATA  <= ren_g[1] ? uq_out_data[1] : uq_out_data[0];
      DISPATCH     <= disp_d;
      DISPATCH_CNT <= disp_cnt_d;
      ROB_FULL[0]  <= (rob_cnt_q[0] + {{(HW-1){1'b0}}, rob_take[0]}) >= `TTA_ROB_HALF;
      ROB_FULL[1]  <= (rob_cnt_q[1] + {{(HW-1){1'b0}}, rob_take[1]}) >= `TTA_ROB_HALF;
      RETIRE       <= ret_g;
      COMMIT       <= com_g;
    end
  end
endmodule // tta_arbiter

// ===== verification/tta_checker.sv
// port assertions for the two-thread arbiter
`timescale 1ns/1ps
module tta_checker (
  input wire       CLK,
  input wire       RSTN,
  input wire [1:0] FETCH_REQ,
  input wire [1:0] FETCH_MISS,
  input wire [1:0] FILL_RETURN,
  input wire [1:0] FETCH_GNT,
  input wire [5:0] SCHED_READY,
  input wire [5:0] DISPATCH,
  input wire [2:0] DISPATCH_CNT,
  input wire [1:0] STORE_PEND,
  input wire [1:0] COMMIT
);
  // stall shadow; a miss wins over a fill in the same cycle
  reg [1:0] st_q;
  always @(posedge CLK) st_q <= RSTN ? (st_q & ~FILL_RETURN) | FETCH_MISS : 2'h0;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence both_f;
    FETCH_REQ == 2'h3 && st_q == 2'h0 && FETCH_MISS == 2'h0;
  endsequence
  chk_fetch_alt: assert property (both_f ##1 both_f |=> FETCH_GNT == ~$past(FETCH_GNT))
    else $error("fetch grant kept owner");
  chk_fetch_stall: assert property (st_q == 2'h1 && FILL_RETURN == 2'h0
    && FETCH_MISS == 2'h0 && FETCH_REQ[1] |=> FETCH_GNT == 2'h2) else $error("stall slots");
  chk_fetch_solo: assert property (FETCH_REQ == 2'h2 && FETCH_MISS == 2'h0 && !st_q[1]
    |=> FETCH_GNT == 2'h2) else $error("lone fetch not granted");
  chk_disp_pass: assert property (1'b1 |=> DISPATCH == $past(SCHED_READY))
    else $error("dispatch lanes differ");
  chk_disp_cnt: assert property (DISPATCH_CNT == $countones(DISPATCH) && DISPATCH_CNT <= 3'h6)
    else $error("dispatch count wrong");
  chk_commit_alt: assert property ($past(STORE_PEND) == 2'h3 && STORE_PEND == 2'h3
    && $onehot(COMMIT) |=> COMMIT == ~$past(COMMIT)) else $error("commit kept owner");
  chk_commit_solo: assert property (STORE_PEND == 2'h2 |=> COMMIT == 2'h2)
    else $error("lone commit not granted");
  chk_commit_idle: assert property (STORE_PEND == 2'h0 |=> COMMIT == 2'h0)
    else $error("commit without store");
endmodule // tta_checker

// ===== verification/tta_rename_model.sv
// rename stage model: takes every uop it is handed
`timescale 1ns/1ps
module tta_rename_model (
  input  wire        clk,
  input  wire [1:0]  stall,
  input  wire [1:0]  valid,
  input  wire [15:0] data,
  output wire [1:0]  ready,
  output reg  [15:0] last0,
  output reg  [3:0]  cnt0,
  output reg  [3:0]  cnt1
);
  assign ready = ~stall;
  // counts are never cleared, so one model serves one run only
  initial {cnt0, cnt1} = 8'h00;
  always @(posedge clk)
  begin
    if (valid[0]) {last0, cnt0} <= {data, cnt0 + 4'h1};
    if (valid[1]) cnt1 <= cnt1 + 4'h1;
  end
endmodule // tta_rename_model

// ===== verification/tta_arbiter_tb.sv
// bench for the two-thread arbiter
`timescale 1ns/1ps
module tta_arbiter_tb;
  reg  [1:0]  freq = 2'h0, miss = 2'h0, fill = 2'h0, uv = 2'h0, stall = 2'h0;
  reg  [1:0]  ra = 2'h0, rd = 2'h0, sp = 2'h0;
  reg         clk = 1'h0, rstn = 1'h0;
  reg  [15:0] ud = 16'h0;
  reg  [5:0]  sr = 6'h0;
  wire [1:0]  gnt, urdy, rr, rv, full, ret, cmt;
  wire [15:0] rdat, last0;
  wire [5:0]  disp;
  wire [2:0]  dcnt;
  wire [3:0]  cnt0, cnt1;
  integer     errors = 0, checks_done = 0, cyc = 0, i;
  always #50 clk = ~clk;
  tta_arbiter i_tta_arbiter (.CLK(clk), .RSTN(rstn), .FETCH_REQ(freq), .FETCH_MISS(miss),
    .FILL_RETURN(fill), .FETCH_GNT(gnt), .UOP_VALID(uv), .UOP_DATA(ud), .UOP_READY(urdy),
    .RENAME_READY(rr), .RENAME_VALID(rv), .RENAME_DATA(rdat), .SCHED_READY(sr),
    .DISPATCH(disp), .DISPATCH_CNT(dcnt), .ROB_ALLOC(ra), .ROB_DONE(rd), .ROB_FULL(full),
    .RETIRE(ret), .STORE_PEND(sp), .COMMIT(cmt));
  tta_rename_model i_tta_rename_model (.clk(clk), .stall(stall), .valid(rv), .data(rdat),
    .ready(rr), .last0(last0), .cnt0(cnt0), .cnt1(cnt1));
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task cy;
  begin
    @(posedge clk);
    #1;
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 500)
    begin
      errors = errors + 1;
      give_verdict;
    end
  end
  initial
  begin
    repeat (6) cy;
    rstn = 1'h1;
    freq = 2'h3;
    sp = 2'h3;
    for (i = 0; i < 4; i = i + 1)
    begin
      cy;
      chk(gnt, i[0] ? 2'h2 : 2'h1);
      chk(cmt, i[0] ? 2'h2 : 2'h1);
    end
    miss = 2'h1;
    sp = 2'h2;
    for (i = 0; i < 3; i = i + 1)
    begin
      cy;
      miss = 2'h0;
      chk(gnt, 2'h2);
      chk(cmt, 2'h2);
    end
    {fill, freq, sp} = 6'h10;
    $display("fetch and commit done");
    for (i = 0; i < 64; i = i + 9)
    begin
      sr = i;
      cy;
      chk(disp, sr);
      chk(dcnt, $countones(sr));
    end
    $display("dispatch done");
    {fill, stall, uv} = 6'h05;
    for (i = 0; i < 10; i = i + 1)
    begin
      ud = 16'hA0 + i;
      cy;
    end
    {uv, ud} = {2'h2, 16'hBEEF};
    cy;
    uv = 2'h0;
    repeat (3) cy;
    chk(cnt1, 4'h1);
    chk(urdy, 2'h2);
    stall = 2'h0;
    repeat (12) cy;
    chk(cnt0, 4'h8);
    chk(last0, 16'hA7);
    $display("uop queue done");
    ra = 2'h1;
    repeat (15) cy;
    chk(full, 2'h0);
    cy;
    ra = 2'h0;
    chk(full, 2'h1);
    rd = 2'h3;
    cy;
    chk(ret, 2'h1);
    $display("reorder done");
    give_verdict;
  end
endmodule // tta_arbiter_tb
bind tta_arbiter tta_checker i_tta_checker (.CLK, .RSTN, .FETCH_REQ, .FETCH_MISS, .FILL_RETURN,
  .FETCH_GNT, .SCHED_READY, .DISPATCH, .DISPATCH_CNT, .STORE_PEND, .COMMIT);
